// *** gpio_psp_defines.vh ***
// register offsets, field positions and reset values for the dual gpio port block
`ifndef GPIO_PSP_DEFINES_VH
`define GPIO_PSP_DEFINES_VH

// register byte offsets on the apb bus
`define OFS_WIDE_PINS    8'h00
`define OFS_WIDE_LATCH   8'h04
`define OFS_WIDE_DIR     8'h08
`define OFS_NARROW_PINS  8'h0C
`define OFS_NARROW_LATCH 8'h10
`define OFS_NARROW_CTRL  8'h14
`define OFS_ANALOG_SEL   8'h18

// fields of the narrow direction and slave control register
`define BIT_IN_FULL      7
`define BIT_OUT_FULL     6
`define BIT_IN_OVERFLOW  5
`define BIT_SLAVE_MODE   4
`define BIT_UNUSED       3
`define NARROW_DIR_MSB   2

// reset values
`define RST_WIDE_DIR     8'hFF
`define RST_NARROW_CTRL  8'h07
`define RST_NARROW_DIR   3'h7
`define RST_WIDE_LATCH   8'h00
`define RST_NARROW_LATCH 3'h0
`define RST_ANALOG_SEL   3'h0

`endif

// *** gpio_pin_bank.v ***
// pin driver and read path for one bank of bidirectional port pins
`timescale 1ns/1ps

module gpio_pin_bank #(
    parameter W = 8
) (
    // configuration
    input  wire [W-1:0] direction,
    input  wire [W-1:0] latchValue,
    input  wire [W-1:0] analogSel,
    input  wire         forceInput,
    // pins
    input  wire [W-1:0] pinIn,
    output wire [W-1:0] pinOut,
    output wire [W-1:0] pinOe,
    // read path
    output wire [W-1:0] pinValue
);

    // one in direction tri-states the driver, zero drives the latch
    assign pinOe    = forceInput ? {W{1'b0}} : ~direction;
    assign pinOut   = latchValue;
    // analog-selected pins read back as zero
    assign pinValue = pinIn & ~analogSel;

endmodule // gpio_pin_bank

// *** psp_strobe_detect.v ***
// detects first-low of chip select with write or read strobe on the slave port
`timescale 1ns/1ps

module psp_strobe_detect (
    // clock and reset
    input  wire sys_clk,
    input  wire reset_n,
    // control
    input  wire enable,
    // strobes, active low
    input  wire readStrobe_n,
    input  wire writeStrobe_n,
    input  wire chipSelect_n,
    // events
    output wire writeEvent,
    output wire readEvent,
    output wire readActive
);

    reg  writeSeen;
    reg  readSeen;
    wire writeLow;
    wire readLow;

    assign writeLow = enable & ~chipSelect_n & ~writeStrobe_n;
    assign readLow  = enable & ~chipSelect_n & ~readStrobe_n;

    // remember the previous sample so only the first low pair counts
    always @(posedge sys_clk) begin
        if (!reset_n) begin
            writeSeen <= 1'b0;
            readSeen  <= 1'b0;
        end else begin
            writeSeen <= writeLow;
            readSeen  <= readLow;
        end
    end

    assign writeEvent = writeLow & ~writeSeen;
    assign readEvent  = readLow & ~readSeen;
    assign readActive = readLow;

endmodule // psp_strobe_detect

// *** dual_port_gpio_psp_ctrl.v ***
// eight-bit and three-bit gpio ports with parallel slave port, apb register access
//
// Overview of operation
// - wide direction bit one tri-states the pin, making it an input
// - wide direction bit zero drives the pin from the output latch
// - wide latch register reads return the latch, not the pins
// - wide port has eight pins, each with its own direction
// - slave mode turns the wide port into a microprocessor data port
// - narrow port has three pins, each input or output
// - narrow latch register reads return the latch, not the pins
// - narrow direction bit one tri-states the matching pin
// - narrow direction bit zero drives the matching latch bit
// - in slave mode the narrow pins are slave control inputs
// - a narrow pin selected as analog reads back as zero
// - narrow direction bits still govern pins selected as analog
// - input full flag is set while a received word awaits reading
// - output full flag is set until the written word is read
// - overflow sets on a write while input unread, software clears
// - mode bit one selects slave port, zero selects gpio
// - control bits two to zero set narrow pin directions
// - wide direction resets to all ones
// - narrow pins zero, one, two are read, write, chip select strobes
// - an access happens when select and strobe are first both low
`timescale 1ns/1ps
`include "gpio_psp_defines.vh"

module dual_port_gpio_psp_ctrl (
    // clock and reset
    input  wire        sys_clk,
    input  wire        reset_n,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // wide port pins
    input  wire [7:0]  widePinIn,
    output wire [7:0]  widePinOut,
    output wire [7:0]  widePinOe,
    // narrow port pins
    input  wire [2:0]  narrowPinIn,
    output wire [2:0]  narrowPinOut,
    output wire [2:0]  narrowPinOe
);

    ////////////////////////////////////////////////////////////////////////////
    // registers

    reg  [7:0] wideLatch;
    reg  [7:0] wideDir;
    reg  [2:0] narrowLatch;
    reg  [2:0] narrowDir;
    reg  [2:0] analogSel;
    reg        slaveMode;
    reg        inputFull;
    reg        outputFull;
    reg        inputOverflow;
    reg  [7:0] inputBuffer;

    ////////////////////////////////////////////////////////////////////////////
    // next values and internal wires

    reg  [7:0] next_wideLatch;
    reg  [7:0] next_wideDir;
    reg  [2:0] next_narrowLatch;
    reg  [2:0] next_narrowDir;
    reg  [2:0] next_analogSel;
    reg        next_slaveMode;
    reg        next_inputFull;
    reg        next_outputFull;
    reg        next_inputOverflow;
    reg  [7:0] next_inputBuffer;
    reg  [31:0] next_prdata;

    wire       setupPhase;
    wire       accessPhase;
    wire       busWrite;
    wire       busRead;
    wire       addrMapped;
    wire [7:0] wideValue;
    wire [2:0] narrowValue;
    wire [7:0] ctrlValue;
    wire [7:0] wideOeGpio;
    wire [2:0] narrowOeBank;
    wire       extWrite;
    wire       extRead;
    wire       extReadActive;
    wire       cpuLoadsOut;
    wire       cpuTakesIn;

    ////////////////////////////////////////////////////////////////////////////
    // functions

    // true when the offset matches one of the implemented registers
    function mapped;
        input [7:0] a;
        begin
            mapped = (a == `OFS_WIDE_PINS)    || (a == `OFS_WIDE_LATCH)  ||
                     (a == `OFS_WIDE_DIR)     || (a == `OFS_NARROW_PINS) ||
                     (a == `OFS_NARROW_LATCH) || (a == `OFS_NARROW_CTRL) ||
                     (a == `OFS_ANALOG_SEL);
        end
    endfunction

    // zero-extend a byte onto the apb data bus
    function [31:0] widen;
        input [7:0] v;
        begin
            widen = {24'h000000, v};
        end
    endfunction

    // zero-extend a three-bit narrow port value onto the apb data bus
    function [31:0] widen3;
        input [2:0] v;
        begin
            widen3 = {29'h0, v};
        end
    endfunction

    // true for the two offsets that load the wide output latch
    function wideWordAddr;
        input [7:0] a;
        begin
            wideWordAddr = (a == `OFS_WIDE_PINS) || (a == `OFS_WIDE_LATCH);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // apb decode

    // zero-wait slave: every access phase completes in its first cycle
    assign setupPhase  = psel & ~penable;
    assign accessPhase = psel & penable;
    assign pready      = 1'b1;
    assign addrMapped  = mapped(paddr);
    assign pslverr     = accessPhase & ~addrMapped;
    assign busWrite    = accessPhase & pwrite & addrMapped;
    assign busRead     = accessPhase & ~pwrite & addrMapped;

    // cpu events that move the slave port buffer flags
    assign cpuLoadsOut = busWrite & slaveMode & wideWordAddr(paddr);
    assign cpuTakesIn  = busRead & slaveMode & (paddr == `OFS_WIDE_PINS);

    ////////////////////////////////////////////////////////////////////////////
    // pin banks

    // wide bank; in slave mode the gpio drivers are replaced below
    // wide pins have no analog select, so that mask is tied off
    gpio_pin_bank #(
        .W          (8)
    ) u_wide_bank (
        .direction  (wideDir),
        .latchValue (wideLatch),
        .analogSel  (8'h00),
        .forceInput (slaveMode),
        .pinIn      (widePinIn),
        .pinOut     (widePinOut),
        .pinOe      (wideOeGpio),
        .pinValue   (wideValue)
    );

    // narrow bank; slave mode turns every pin into a strobe input
    gpio_pin_bank #(
        .W          (3)
    ) u_narrow_bank (
        .direction  (narrowDir),
        .latchValue (narrowLatch),
        .analogSel  (analogSel),
        .forceInput (slaveMode),
        .pinIn      (narrowPinIn),
        .pinOut     (narrowPinOut),
        .pinOe      (narrowOeBank),
        .pinValue   (narrowValue)
    );

    assign narrowPinOe = narrowOeBank;

    // external master reads the latch only while select and read are low
    assign widePinOe = slaveMode ? {8{extReadActive}} : wideOeGpio;

    ////////////////////////////////////////////////////////////////////////////
    // slave port strobes

    // pin zero is read, pin one is write, pin two is chip select
    // strobes are sampled on sys_clk, so a pulse must span a rising edge
    psp_strobe_detect u_strobes (
        .sys_clk       (sys_clk),
        .reset_n       (reset_n),
        .enable        (slaveMode),
        .readStrobe_n  (narrowPinIn[0]),
        .writeStrobe_n (narrowPinIn[1]),
        .chipSelect_n  (narrowPinIn[2]),
        .writeEvent    (extWrite),
        .readEvent     (extRead),
        .readActive    (extReadActive)
    );

    ////////////////////////////////////////////////////////////////////////////
    // control register image

    // bit three is unimplemented and always reads zero
    assign ctrlValue = {inputFull, outputFull, inputOverflow, slaveMode,
                        1'b0, narrowDir};

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic

    // register writes, slave port events and flag updates
    always @* begin
        next_wideLatch     = wideLatch;
        next_wideDir       = wideDir;
        next_narrowLatch   = narrowLatch;
        next_narrowDir     = narrowDir;
        next_analogSel     = analogSel;
        next_slaveMode     = slaveMode;
        next_inputFull     = inputFull;
        next_outputFull    = outputFull;
        next_inputOverflow = inputOverflow;
        next_inputBuffer   = inputBuffer;

        // cpu writes
        if (busWrite) begin
            case (paddr)
                `OFS_WIDE_PINS: begin
                    next_wideLatch = pwdata[7:0];
                end
                `OFS_WIDE_LATCH: begin
                    next_wideLatch = pwdata[7:0];
                end
                `OFS_WIDE_DIR: begin
                    next_wideDir = pwdata[7:0];
                end
                `OFS_NARROW_PINS: begin
                    next_narrowLatch = pwdata[2:0];
                end
                `OFS_NARROW_LATCH: begin
                    next_narrowLatch = pwdata[2:0];
                end
                `OFS_NARROW_CTRL: begin
                    // flags in bits seven and six are read only
                    next_narrowDir = pwdata[`NARROW_DIR_MSB:0];
                    next_slaveMode = pwdata[`BIT_SLAVE_MODE];
                    // writing one to the overflow bit leaves it as it is
                    if (!pwdata[`BIT_IN_OVERFLOW]) begin
                        next_inputOverflow = 1'b0;
                    end
                end
                `OFS_ANALOG_SEL: begin
                    next_analogSel = pwdata[2:0];
                end
                default: begin
                    next_analogSel = analogSel;
                end
            endcase
        end

        // cpu read of the wide port in slave mode takes the received word
        if (cpuTakesIn) begin
            next_inputFull = 1'b0;
        end

        // external master read drains the output word
        if (extRead) begin
            next_outputFull = 1'b0;
        end

        // a cpu load in the same cycle wins over the drain
        if (cpuLoadsOut) begin
            next_outputFull = 1'b1;
        end

        // external master write; set wins over a clear in the same cycle
        if (extWrite) begin
            next_inputBuffer = widePinIn;
            next_inputFull   = 1'b1;
            if (inputFull) begin
                next_inputOverflow = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data

    // read data is sampled in the setup cycle and held for the access cycle
    // an external write between setup and access shows on the next read
    always @* begin
        next_prdata = prdata;
        if (setupPhase) begin
            case (paddr)
                `OFS_WIDE_PINS:    next_prdata = widen(slaveMode ? inputBuffer : wideValue);
                `OFS_WIDE_LATCH:   next_prdata = widen(wideLatch);
                `OFS_WIDE_DIR:     next_prdata = widen(wideDir);
                `OFS_NARROW_PINS:  next_prdata = widen3(narrowValue);
                `OFS_NARROW_LATCH: next_prdata = widen3(narrowLatch);
                `OFS_NARROW_CTRL:  next_prdata = widen(ctrlValue);
                `OFS_ANALOG_SEL:   next_prdata = widen3(analogSel);
                default:           next_prdata = 32'h00000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state registers

    // all state with synchronous reset
    always @(posedge sys_clk) begin
        if (!reset_n) begin
            wideLatch     <= `RST_WIDE_LATCH;
            wideDir       <= `RST_WIDE_DIR;
            narrowLatch   <= `RST_NARROW_LATCH;
            narrowDir     <= `RST_NARROW_DIR;
            analogSel     <= `RST_ANALOG_SEL;
            slaveMode     <= 1'b0;
            inputFull     <= 1'b0;
            outputFull    <= 1'b0;
            inputOverflow <= 1'b0;
            inputBuffer   <= 8'h00;
            prdata        <= 32'h00000000;
        end else begin
            wideLatch     <= next_wideLatch;
            wideDir       <= next_wideDir;
            narrowLatch   <= next_narrowLatch;
            narrowDir     <= next_narrowDir;
            analogSel     <= next_analogSel;
            slaveMode     <= next_slaveMode;
            inputFull     <= next_inputFull;
            outputFull    <= next_outputFull;
            inputOverflow <= next_inputOverflow;
            inputBuffer   <= next_inputBuffer;
            prdata        <= next_prdata;
        end
    end

endmodule // dual_port_gpio_psp_ctrl

// *** gpio_psp_properties.sv ***
// concurrent checks on the ports of the dual gpio port block
`timescale 1ns/1ps

module gpio_psp_properties (
    // clock and reset
    input wire        sys_clk,
    input wire        reset_n,
    // apb
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] pwdata,
    // pins
    input wire [2:0]  narrowPinIn,
    input wire [7:0]  widePinOut,
    input wire [7:0]  widePinOe,
    input wire [2:0]  narrowPinOut,
    input wire [2:0]  narrowPinOe
);
    wire       wrAcc = psel && penable && pwrite;
    reg  [7:0] wideDir;
    reg  [2:0] narrowDir;
    reg        slaveMode;
    ////////////////////////////////////////////////////////////////
    // mirror of direction and mode bits as software wrote them
    always @(posedge sys_clk) begin
        if (!reset_n) begin
            wideDir   <= 8'hFF;
            narrowDir <= 3'h7;
            slaveMode <= 1'b0;
        end else if (wrAcc && paddr == 8'h08) begin
            wideDir <= pwdata[7:0];
        end else if (wrAcc && paddr == 8'h14) begin
            narrowDir <= pwdata[2:0];
            slaveMode <= pwdata[4];
        end
    end
    ////////////////////////////////////////////////////////////////
    a_reset_inputs: assert property (@(posedge sys_clk)
        !reset_n |=> widePinOe == 8'h00 && narrowPinOe == 3'h0) else $error("pins driven after reset");
    a_wide_dir_gpio: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !slaveMode |-> widePinOe == ~wideDir) else $error("wide enable differs from direction");
    a_slave_read_drive: assert property (@(posedge sys_clk) disable iff (!reset_n)
        slaveMode && !narrowPinIn[2] && !narrowPinIn[0] |-> widePinOe == 8'hFF) else $error("no drive on read");
    a_slave_bus_float: assert property (@(posedge sys_clk) disable iff (!reset_n)
        slaveMode && (narrowPinIn[2] || narrowPinIn[0]) |-> widePinOe == 8'h00) else $error("bus driven idle");
    a_narrow_dir_gpio: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !slaveMode |-> narrowPinOe == ~narrowDir) else $error("narrow enable differs from direction");
    a_narrow_slave_in: assert property (@(posedge sys_clk) disable iff (!reset_n)
        slaveMode |-> narrowPinOe == 3'h0) else $error("narrow pin driven in slave mode");
    a_wide_latch_out: assert property (@(posedge sys_clk) disable iff (!reset_n)
        wrAcc && paddr == 8'h04 |=> widePinOut == $past(pwdata[7:0])) else $error("wide latch not driven");
    a_narrow_latch_out: assert property (@(posedge sys_clk) disable iff (!reset_n)
        wrAcc && paddr == 8'h10 |=> narrowPinOut == $past(pwdata[2:0])) else $error("narrow latch not driven");
endmodule // gpio_psp_properties

bind dual_port_gpio_psp_ctrl gpio_psp_properties i_gpio_psp_properties (.sys_clk, .reset_n, .psel,
    .penable, .pwrite, .paddr, .pwdata, .narrowPinIn, .widePinOut, .widePinOe, .narrowPinOut, .narrowPinOe);

// *** psp_host_model.sv ***
// external microprocessor on the slave port, also the pin source in gpio mode
`timescale 1ns/1ps

module psp_host_model (
    // clock
    input  wire       sys_clk,
    // resolved data pins
    input  wire [7:0] widePins,
    // drive towards the block
    output reg  [7:0] hostData,
    output reg  [2:0] strobes_n
);
    initial begin
        hostData  = 8'h00;
        strobes_n = 3'h7;
    end
    // plain pin levels in gpio mode
    task drivePins(input [7:0] d, input [2:0] s);
        begin
            @(posedge sys_clk);
            hostData  <= d;
            strobes_n <= s;
        end
    endtask
    // one strobe: bit 0 read, bit 1 write, bit 2 select
    task access(input integer w, input [7:0] d, output [7:0] q);
        begin
            @(posedge sys_clk);
            hostData  <= w ? d : ~hostData;
            strobes_n <= w ? 3'b001 : 3'b010;
            repeat (3) @(posedge sys_clk);
            q = widePins;
            strobes_n <= 3'h7;
            @(posedge sys_clk);
            hostData  <= ~hostData; // released bus keeps no stale value
        end
    endtask
endmodule // psp_host_model

// *** test_dual_port_gpio_psp_ctrl.sv ***
// self-checking bench for the dual gpio port block
`timescale 1ns/1ps
`include "gpio_psp_defines.vh"

module test_dual_port_gpio_psp_ctrl;
    reg         sys_clk, reset_n, psel, penable, pwrite, err;
    reg  [7:0]  paddr, lat, dir, q;
    reg  [31:0] pwdata, rnd, rd;
    reg  [2:0]  nd;
    wire [31:0] prdata;
    wire        pready, pslverr;
    wire [7:0]  widePinOut, widePinOe, hostData;
    wire [2:0]  narrowPinOut, narrowPinOe, strobes_n;
    wire [7:0]  widePinIn = (widePinOut & widePinOe) | (hostData & ~widePinOe);
    wire [2:0]  narrowPinIn = (narrowPinOut & narrowPinOe) | (strobes_n & ~narrowPinOe);
    integer     n_mismatch, comparisons, i;

    dual_port_gpio_psp_ctrl i_dual_port_gpio_psp_ctrl (.sys_clk, .reset_n, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .widePinIn, .widePinOut, .widePinOe,
        .narrowPinIn, .narrowPinOut, .narrowPinOe);
    psp_host_model i_psp_host_model (.sys_clk, .widePins(widePinIn), .hostData, .strobes_n);
    ////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    // verdict
    task finish_test;
        begin
            if (n_mismatch == 0 && comparisons > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    task check(input [95:0] n, input [31:0] seen, input [31:0] exp);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("MISMATCH %0s expected %h seen %h", n, exp, seen);
            end
        end
    endtask
    // one apb transfer, read data and error taken at the ready edge
    task apb(input w, input [7:0] a, input [31:0] d);
        integer k;
        begin
            @(posedge sys_clk);
            psel   <= 1'b1;
            pwrite <= w;
            paddr  <= a;
            pwdata <= d;
            @(posedge sys_clk);
            penable <= 1'b1;
            for (k = 0; k < 16; k = k + 1) begin
                @(posedge sys_clk);
                if (pready === 1'b1) begin
                    rd  = prdata;
                    err = pslverr;
                    k   = 99;
                end
            end
            psel    <= 1'b0;
            penable <= 1'b0;
            if (k != 100) begin
                n_mismatch = n_mismatch + 1;
                finish_test;
            end
        end
    endtask
    task rdchk(input [7:0] a, input [31:0] e, input [95:0] n);
        begin
            apb(1'b0, a, 32'h0);
            check(n, rd, e);
        end
    endtask
    function [31:0] step(input [31:0] s);
        step = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function [7:0] pinsExp(input [7:0] l, input [7:0] d, input [7:0] h);
        pinsExp = (l & ~d) | (h & d);
    endfunction
    ////////////////////////////////////////////////////////////////
    initial begin
        {reset_n, psel, penable, pwrite, err} = 5'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        n_mismatch = 0;
        comparisons = 0;
        rnd = 32'd76276;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        rdchk(`OFS_WIDE_DIR, `RST_WIDE_DIR, "wide dir");
        rdchk(`OFS_NARROW_CTRL, `RST_NARROW_CTRL, "ctrl");
        rdchk(8'h1C, 32'h0, "unmapped");
        check("slverr", err, 32'h1);
        // random latch, direction and pin levels on both ports
        for (i = 0; i < 12; i = i + 1) begin
            rnd = step(rnd);
            lat = rnd[7:0];
            dir = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : rnd[15:8];
            nd = dir[2:0] | rnd[26:24];
            i_psp_host_model.drivePins(rnd[23:16], rnd[30:28]);
            apb(1'b1, i[0] ? `OFS_WIDE_PINS : `OFS_WIDE_LATCH, lat);
            apb(1'b1, `OFS_WIDE_DIR, dir);
            apb(1'b1, i[0] ? `OFS_NARROW_PINS : `OFS_NARROW_LATCH, lat);
            apb(1'b1, `OFS_ANALOG_SEL, rnd[26:24]);
            apb(1'b1, `OFS_NARROW_CTRL, nd);
            rdchk(`OFS_WIDE_LATCH, lat, "wide latch");
            rdchk(`OFS_WIDE_DIR, dir, "wide dir rd");
            rdchk(`OFS_ANALOG_SEL, rnd[26:24], "analog sel");
            rdchk(`OFS_WIDE_PINS, pinsExp(lat, dir, rnd[23:16]), "wide pins");
            rdchk(`OFS_NARROW_LATCH, lat[2:0], "narrow latch");
            rdchk(`OFS_NARROW_PINS, pinsExp(lat[2:0], nd, rnd[30:28]) & ~{5'h0, rnd[26:24]}, "narrow pins");
            check("wide oe", widePinOe, {~dir});
            check("narrow oe", narrowPinOe, {~nd});
        end
        // read-only bits, then strobes ignored in gpio mode
        i_psp_host_model.drivePins(8'h00, 3'h7);
        apb(1'b1, `OFS_NARROW_CTRL, 32'hEF);
        rdchk(`OFS_NARROW_CTRL, 32'h07, "ctrl ro");
        i_psp_host_model.access(1, 8'h5A, q);
        rdchk(`OFS_NARROW_CTRL, 32'h07, "gpio mode");
        // slave port words in both directions
        apb(1'b1, `OFS_NARROW_CTRL, 32'h17);
        rnd = step(rnd);
        i_psp_host_model.access(1, rnd[7:0], q);
        rdchk(`OFS_NARROW_CTRL, 32'h97, "ctrl ibf");
        rdchk(`OFS_WIDE_PINS, rnd[7:0], "slave in");
        rdchk(`OFS_NARROW_CTRL, 32'h17, "ibf clear");
        i_psp_host_model.access(1, rnd[15:8], q);
        i_psp_host_model.access(1, rnd[23:16], q);
        rdchk(`OFS_NARROW_CTRL, 32'hB7, "ctrl ovf");
        apb(1'b1, `OFS_NARROW_CTRL, 32'hF7);
        apb(1'b0, `OFS_WIDE_PINS, 32'h0);
        rdchk(`OFS_NARROW_CTRL, 32'h37, "ovf stays");
        apb(1'b1, `OFS_NARROW_CTRL, 32'h17);
        rdchk(`OFS_NARROW_CTRL, 32'h17, "ovf clear");
        apb(1'b1, `OFS_WIDE_PINS, rnd[31:24]);
        rdchk(`OFS_NARROW_CTRL, 32'h57, "ctrl obf");
        i_psp_host_model.access(0, 8'h00, q);
        check("slave out", q, rnd[31:24]);
        rdchk(`OFS_NARROW_CTRL, 32'h17, "obf clear");
        finish_test;
    end
endmodule // test_dual_port_gpio_psp_ctrl
